// >>> pkg/ztpt_pkg.sv
// package of constants and types for the zero tare peak tracker
package ztpt_pkg;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [11:0] ztpt_a_ctrl = 12'h000;
  localparam logic [11:0] ztpt_a_refv = 12'h004;
  localparam logic [11:0] ztpt_a_meas = 12'h008;
  localparam logic [11:0] ztpt_a_disp = 12'h00c;
  localparam logic [11:0] ztpt_a_max = 12'h010;
  localparam logic [11:0] ztpt_a_min = 12'h014;
  localparam logic [11:0] ztpt_a_sp0 = 12'h018;
  localparam logic [11:0] ztpt_a_stat = 12'h028;
  localparam logic [11:0] ztpt_a_peak_clr = 12'h02c;

  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int ztpt_c_zlock = 0;
  localparam int ztpt_c_plock = 2;
  localparam int ztpt_c_sdret = 4;
  localparam int ztpt_c_iocode = 8;
  localparam logic [31:0] ztpt_ctrl_rst = 32'h0000_0000;

  // ****************************************************************
  // value limits and codes
  // ****************************************************************
  localparam logic signed [31:0] ztpt_sp_min = -32'sd20000;
  localparam logic signed [31:0] ztpt_sp_max = 32'sd100000;
  localparam logic [31:0] ztpt_sp_off = 32'h8000_0000;
  localparam logic [3:0] ztpt_io_6 = 4'h6;
  localparam logic [3:0] ztpt_io_a = 4'ha;
  localparam logic [1:0] ztpt_lv_none = 2'h0;
  localparam logic [1:0] ztpt_lv_partial = 2'h1;
  localparam logic [1:0] ztpt_lv_full = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint ztpt_clk_hz = 40000000;
  localparam longint ztpt_hold1_ms = 1000;
  localparam longint ztpt_hold2_ms = 2000;
  localparam longint ztpt_pwr_ms = 3000;
  localparam longint ztpt_ret_ms = 5000;
  localparam int ztpt_hold1_cyc = int'(ztpt_hold1_ms * ztpt_clk_hz / 1000);
  localparam int ztpt_hold2_cyc = int'(ztpt_hold2_ms * ztpt_clk_hz / 1000);
  localparam int ztpt_pwr_cyc = int'(ztpt_pwr_ms * ztpt_clk_hz / 1000);
  localparam int ztpt_ret_cyc = int'(ztpt_ret_ms * ztpt_clk_hz / 1000);

  // ****************************************************************
  // views
  // ****************************************************************
  typedef enum logic [1:0] {
    ztpt_main_present = 2'b00,
    ztpt_main_max = 2'b01,
    ztpt_main_min = 2'b11
  } ztpt_main_t;

  typedef enum logic [2:0] {
    ztpt_sd_bank = 3'b000,
    ztpt_sd_ll = 3'b001,
    ztpt_sd_l = 3'b011,
    ztpt_sd_h = 3'b010,
    ztpt_sd_hh = 3'b110
  } ztpt_sd_t;

endpackage : ztpt_pkg

// >>> pkg/ztpt_key_if.sv
// interface carrying one key timer's press and hold events
`timescale 1ns/1ps
interface ztpt_key_if;
  logic level;
  logic press;
  logic hold1;
  logic hold2;
  modport timer (input level, output press, output hold1, output hold2);
  modport user (output level, input press, input hold1, input hold2);
endinterface : ztpt_key_if

// >>> src/ztpt_key_timer.sv
// key press edge and hold time detector
`timescale 1ns/1ps
module ztpt_key_timer
  import ztpt_pkg::*;
#(
  parameter int hold1_cyc = ztpt_hold1_cyc,
  parameter int hold2_cyc = ztpt_hold2_cyc
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // key events
  ztpt_key_if.timer k
);

  // refuse hold marks the counter cannot order
  if (hold1_cyc < 1 || hold2_cyc <= hold1_cyc) begin : g_bad_hold
    $error("hold counts out of order");
  end

  typedef struct packed {
    logic lvl;
    logic [31:0] cnt;
    logic press;
    logic hold1;
    logic hold2;
  } ztpt_kt_t;

  ztpt_kt_t s_q;
  ztpt_kt_t s_d;

  // count held time, pulse at rise and at each hold mark
  always_comb begin
    s_d = s_q;
    s_d.lvl = k.level;
    s_d.press = k.level && !s_q.lvl;
    s_d.hold1 = 1'b0;
    s_d.hold2 = 1'b0;
    if (!k.level) begin
      s_d.cnt = '0;
    end else if (s_q.cnt < 32'(hold2_cyc)) begin
      s_d.cnt = s_q.cnt + 32'd1;
      s_d.hold1 = (s_q.cnt + 32'd1) == 32'(hold1_cyc);
      s_d.hold2 = (s_q.cnt + 32'd1) == 32'(hold2_cyc);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign k.press = s_q.press;
  assign k.hold1 = s_q.hold1;
  assign k.hold2 = s_q.hold2;

endmodule : ztpt_key_timer

// >>> src/ztpt_top.sv
// panel meter control: setpoints, zero and tare, peak tracking
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
//
// Function
// - keyed setpoints clamp to -20000 .. 100000
// - disable code on a setpoint turns that alarm output off
// - alarm key commits edit and steps ll, l, h, hh
// - option off: secondary view returns to bank after timeout
// - up key in measuring captures zero reference, shows reference value
// - up key during forced zero adds tare; repeats allowed
// - unlocked: hold one second cancels tare
// - unlocked: hold two seconds cancels tare then forced zero
// - partial lock: press does zero only, hold cancels zero
// - zero lockout has three levels, unlocked by default
// - io code 6 or a: external zero input acts as up key
// - lockout gates front keys only, not external input
// - peak view ignores executes, honours cancels
// - zero and tare work during out of range
// - external reset rejects every zero and tare request
// - reference value configurable, default zero
// - max/min key steps present, max, min, present
// - running max and min update always during measuring
// - max/min key hold one second clears and restarts peaks
// - peaks held in reset about three seconds after power-up
// - peak lockout: none, reset blocked, display blocked
// - peak lockout gates keys only; bus and reset still act
// - external reset clears peaks, alarm latch, stops measuring
module ztpt_top
  import ztpt_pkg::*;
#(
  parameter int pwr_cyc = ztpt_pwr_cyc,
  parameter int ret_cyc = ztpt_ret_cyc,
  parameter int hold1_cyc = ztpt_hold1_cyc,
  parameter int hold2_cyc = ztpt_hold2_cyc
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // front keys and discrete inputs
  input wire logic key_alarm,
  input wire logic key_up,
  input wire logic key_shift,
  input wire logic key_maxmin,
  input wire logic ext_zero,
  input wire logic ext_reset,
  input wire logic out_of_range,
  // measurement in
  input wire logic meas_valid,
  input wire logic signed [31:0] meas_value,
  // display and outputs
  output logic signed [31:0] display_value,
  output logic [1:0] main_view,
  output logic [2:0] secondary_readout,
  output logic [3:0] alarm_enable,
  output logic alarm_latch_clr,
  output logic peak_valid
);

  // refuse timing counts the counters cannot serve
  if (pwr_cyc < 1 || ret_cyc < 1) begin : g_bad_timing
    $error("timing counts must be positive");
  end

  // ****************************************************************
  // key timers
  // ****************************************************************
  ztpt_key_if up_k ();
  ztpt_key_if mm_k ();
  ztpt_key_if al_k ();

  logic ext_ok;
  assign up_k.level = key_up || (ext_zero && ext_ok);
  assign mm_k.level = key_maxmin;
  assign al_k.level = key_alarm;

  ztpt_key_timer #(.hold1_cyc(hold1_cyc), .hold2_cyc(hold2_cyc)) u_up (
    .pclk(pclk), .presetn(presetn), .k(up_k.timer));
  ztpt_key_timer #(.hold1_cyc(hold1_cyc), .hold2_cyc(hold2_cyc)) u_mm (
    .pclk(pclk), .presetn(presetn), .k(mm_k.timer));
  ztpt_key_timer #(.hold1_cyc(hold1_cyc), .hold2_cyc(hold2_cyc)) u_al (
    .pclk(pclk), .presetn(presetn), .k(al_k.timer));

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic signed [31:0] refv;
    logic signed [31:0] meas;
    logic signed [31:0] zero_off;
    logic signed [31:0] tare_off;
    logic zero_on;
    logic tare_on;
    logic src_ext;
    logic signed [31:0] pmax;
    logic signed [31:0] pmin;
    logic pvalid;
    logic [31:0] pwr_cnt;
    logic [31:0] ret_cnt;
    ztpt_main_t mview;
    ztpt_sd_t sview;
    logic editing;
    logic signed [31:0] edit_val;
    logic [3:0][31:0] sp;
    logic signed [31:0] disp;
    logic [3:0] alm_en;
    logic latch_clr;
    logic [31:0] rdata;
    logic ready;
  } ztpt_st_t;

  ztpt_st_t s_q;
  ztpt_st_t s_d;

  logic [1:0] ctrl_zlock;
  logic [1:0] ctrl_plock;
  logic ctrl_sdret;
  logic [3:0] ctrl_iocode;
  assign ctrl_zlock = s_q.ctrl[ztpt_c_zlock +: 2];
  assign ctrl_plock = s_q.ctrl[ztpt_c_plock +: 2];
  assign ctrl_sdret = s_q.ctrl[ztpt_c_sdret];
  assign ctrl_iocode = s_q.ctrl[ztpt_c_iocode +: 4];
  assign ext_ok = (ctrl_iocode == ztpt_io_6) || (ctrl_iocode == ztpt_io_a);

  logic acc;
  logic wr;
  assign acc = psel && penable && !s_q.ready;
  assign wr = psel && penable && pwrite && s_q.ready;

  // index of setpoint shown on the secondary readout
  function automatic logic [1:0] sd_idx(input ztpt_sd_t v);
    logic [1:0] r;
    r = 2'd0;
    unique case (v)
      ztpt_sd_l: r = 2'd1;
      ztpt_sd_h: r = 2'd2;
      ztpt_sd_hh: r = 2'd3;
      default: r = 2'd0;
    endcase
    return r;
  endfunction : sd_idx

  // clamp a keyed setpoint into range, passing the disable code
  function automatic logic [31:0] sp_clamp(input logic signed [31:0] v);
    logic [31:0] r;
    r = v;
    if (v == ztpt_sp_off) begin
      r = ztpt_sp_off;
    end else if (v < ztpt_sp_min) begin
      r = ztpt_sp_min;
    end else if (v > ztpt_sp_max) begin
      r = ztpt_sp_max;
    end
    return r;
  endfunction : sp_clamp

  logic ext_req;
  logic key_ok_zero;
  logic key_ok_tare;
  logic in_peak;
  logic blocked;
  assign ext_req = ext_zero && ext_ok && !key_up;
  // lockout applies only to the front key; the ext source flop
  // lines up with the timer pulses, which come one cycle late
  assign key_ok_zero = s_q.src_ext || (ctrl_zlock != ztpt_lv_full);
  assign key_ok_tare = s_q.src_ext || (ctrl_zlock == ztpt_lv_none);
  assign in_peak = s_q.mview != ztpt_main_present;
  assign blocked = ext_reset;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.ready = 1'b0;
    s_d.latch_clr = ext_reset;

    // measurement capture, suspended during external reset
    if (meas_valid && !ext_reset) begin
      s_d.meas = meas_value;
    end

    // zero and tare; out of range does not block
    if (!blocked) begin
      if (up_k.press && key_ok_zero && !in_peak) begin
        if (!s_q.zero_on) begin
          s_d.zero_on = 1'b1;
          s_d.zero_off = s_q.meas;
        end else if (key_ok_tare) begin
          s_d.tare_on = 1'b1;
          s_d.tare_off = s_q.meas - s_q.zero_off;
        end
      end
      if (up_k.hold1 && key_ok_zero) begin
        if (s_q.tare_on && key_ok_tare) begin
          s_d.tare_on = 1'b0;
          s_d.tare_off = '0;
        end else if (!key_ok_tare) begin
          s_d.zero_on = 1'b0;
          s_d.zero_off = '0;
        end
      end
      if (up_k.hold2 && key_ok_tare) begin
        s_d.zero_on = 1'b0;
        s_d.zero_off = '0;
        s_d.tare_off = '0;
        s_d.tare_on = 1'b0;
      end
    end

    // display value
    s_d.disp = s_d.meas - s_d.zero_off - s_d.tare_off + s_q.refv;

    // power-up hold and peak tracking
    if (s_q.pwr_cnt < 32'(pwr_cyc)) begin
      s_d.pwr_cnt = s_q.pwr_cnt + 32'd1;
      s_d.pvalid = 1'b0;
    end else if (ext_reset) begin
      s_d.pvalid = 1'b0;
    end else if (mm_k.hold1 && ctrl_plock == ztpt_lv_none) begin
      s_d.pvalid = 1'b0;
    end else if (!s_q.pvalid) begin
      s_d.pmax = s_d.disp;
      s_d.pmin = s_d.disp;
      s_d.pvalid = 1'b1;
    end else begin
      if (s_d.disp > s_q.pmax) begin
        s_d.pmax = s_d.disp;
      end
      if (s_d.disp < s_q.pmin) begin
        s_d.pmin = s_d.disp;
      end
    end

    // main view stepping, blocked at full peak lockout
    if (mm_k.press && ctrl_plock != ztpt_lv_full) begin
      unique case (s_q.mview)
        ztpt_main_present: s_d.mview = ztpt_main_max;
        ztpt_main_max: s_d.mview = ztpt_main_min;
        default: s_d.mview = ztpt_main_present;
      endcase
    end

    // setpoint view, edit and return timer
    if (al_k.press || key_shift || key_up) begin
      s_d.ret_cnt = '0;
    end else if (s_q.sview != ztpt_sd_bank && !ctrl_sdret) begin
      s_d.ret_cnt = s_q.ret_cnt + 32'd1;
      if (s_q.ret_cnt + 32'd1 >= 32'(ret_cyc)) begin
        s_d.sview = ztpt_sd_bank;
        s_d.editing = 1'b0;
        s_d.ret_cnt = '0;
      end
    end
    if (key_shift && s_q.sview != ztpt_sd_bank && !s_q.editing) begin
      s_d.editing = 1'b1;
      s_d.edit_val = s_q.sp[sd_idx(s_q.sview)];
    end
    if (al_k.press) begin
      if (s_q.editing) begin
        s_d.sp[sd_idx(s_q.sview)] = sp_clamp(s_q.edit_val);
        s_d.editing = 1'b0;
      end
      unique case (s_q.sview)
        ztpt_sd_bank: s_d.sview = ztpt_sd_ll;
        ztpt_sd_ll: s_d.sview = ztpt_sd_l;
        ztpt_sd_l: s_d.sview = ztpt_sd_h;
        ztpt_sd_h: s_d.sview = ztpt_sd_hh;
        default: s_d.sview = ztpt_sd_bank;
      endcase
    end

    // alarm enables from setpoints
    for (int i = 0; i < 4; i++) begin
      s_d.alm_en[i] = (s_d.sp[i] != ztpt_sp_off) && !ext_reset;
    end

    // apb access
    if (acc) begin
      s_d.ready = 1'b1;
      s_d.rdata = '0;
      unique case (paddr)
        ztpt_a_ctrl: s_d.rdata = s_q.ctrl;
        ztpt_a_refv: s_d.rdata = s_q.refv;
        ztpt_a_meas: s_d.rdata = s_q.meas;
        ztpt_a_disp: s_d.rdata = s_q.disp;
        ztpt_a_max: s_d.rdata = s_q.pmax;
        ztpt_a_min: s_d.rdata = s_q.pmin;
        ztpt_a_stat: s_d.rdata = {27'h0, s_q.pvalid, s_q.editing,
                                  s_q.tare_on, s_q.zero_on, s_q.src_ext};
        default: begin
          if (paddr >= ztpt_a_sp0 && paddr < ztpt_a_stat) begin
            s_d.rdata = s_q.sp[paddr[3:2] - 2'd2];
          end
        end
      endcase
    end
    // writes land at the edge where ready is seen high
    if (wr) begin
      if (paddr == ztpt_a_ctrl) begin
        s_d.ctrl = pwdata;
      end else if (paddr == ztpt_a_refv) begin
        s_d.refv = pwdata;
      end else if (paddr == ztpt_a_peak_clr && pwdata[0]) begin
        s_d.pvalid = 1'b0;
      end else if (paddr >= ztpt_a_sp0 && paddr < ztpt_a_stat) begin
        s_d.sp[paddr[3:2] - 2'd2] = pwdata;
      end
    end
    s_d.src_ext = ext_req;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= ztpt_ctrl_rst;
      s_q.mview <= ztpt_main_present;
      s_q.sview <= ztpt_sd_bank;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops, except pslverr tied low
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = 1'b0;
  assign display_value = s_q.disp;
  assign main_view = s_q.mview;
  assign secondary_readout = s_q.sview;
  assign alarm_enable = s_q.alm_en;
  assign alarm_latch_clr = s_q.latch_clr;
  assign peak_valid = s_q.pvalid;

endmodule : ztpt_top

// >>> dv/ztpt_keys_model.sv
// front keys, discrete inputs and measurement source
`timescale 1ns/1ps
module ztpt_keys_model (
  // clock
  input wire logic pclk,
  // keys and discrete lines
  output logic key_alarm,
  output logic key_up,
  output logic key_shift,
  output logic key_maxmin,
  output logic ext_zero,
  output logic ext_reset,
  output logic out_of_range,
  // measurement
  output logic meas_valid,
  output logic signed [31:0] meas_value
);
  // ****************************************************************
  // key levels, index order alarm up shift maxmin zero reset range
  // ****************************************************************
  logic [6:0] keys_q = 7'h00;
  initial meas_valid = 1'b0;
  initial meas_value = 32'sd0;
  // released keys fall to idle low
  assign {out_of_range, ext_reset, ext_zero} = keys_q[6:4];
  assign {key_maxmin, key_shift, key_up, key_alarm} = keys_q[3:0];

  // hold one line for n cycles, then let the action settle
  task automatic hold(input int k, input int n);
    @(posedge pclk);
    keys_q[k] <= 1'b1;
    repeat (n) @(posedge pclk);
    keys_q[k] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : hold

  // set a line to a level and leave it
  task automatic lvl(input int k, input logic v);
    @(posedge pclk);
    keys_q[k] <= v;
    repeat (2) @(posedge pclk);
  endtask : lvl

  // one reading strobe; the value is scrambled once invalid
  task automatic meas(input logic signed [31:0] v);
    @(posedge pclk);
    meas_value <= v;
    meas_valid <= 1'b1;
    @(posedge pclk);
    meas_valid <= 1'b0;
    meas_value <= ~v;
    repeat (3) @(posedge pclk);
  endtask : meas
endmodule : ztpt_keys_model

// >>> dv/ztpt_top_asserts.sv
// port timing checker for the zero tare peak tracker
`timescale 1ns/1ps
module ztpt_top_asserts
  import ztpt_pkg::*;
#(
  parameter int pwr_cyc = ztpt_pwr_cyc
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // discrete and views
  input wire logic ext_reset,
  input wire logic [3:0] alarm_enable,
  input wire logic alarm_latch_clr,
  input wire logic [1:0] main_view,
  input wire logic [2:0] secondary_readout,
  input wire logic peak_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since reset release, saturating
  logic [7:0] up_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= 8'h00;
    else if (up_q != 8'hff) up_q <= up_q + 8'h01;
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  no_error_a: assert property (!pslverr)
    else $error("slave error raised");
  latch_rise_a: assert property ($rose(ext_reset) |=> alarm_latch_clr)
    else $error("latch clear missed reset rise");
  latch_fall_a: assert property ($fell(ext_reset) |=> !alarm_latch_clr)
    else $error("latch clear held after reset");
  alarm_off_a: assert property (ext_reset [*2] |-> alarm_enable == 4'h0)
    else $error("alarm output on during reset input");
  sd_code_a: assert property (secondary_readout inside {3'h0, 3'h1,
    3'h3, 3'h2, 3'h6}) else $error("illegal secondary view");
  main_code_a: assert property (main_view != 2'h2)
    else $error("illegal main view");
  peak_wait_a: assert property (up_q < pwr_cyc - 2 |-> !peak_valid)
    else $error("peaks tracked too early");
  peak_start_a: assert property (up_q == pwr_cyc + 4 |-> peak_valid)
    else $error("peaks not tracking after power-up");
  // main scenarios reached
  c_ext_reset: cover property ($rose(ext_reset));
  c_min_view: cover property (main_view == 2'h3);
  c_hh_view: cover property (secondary_readout == 3'h6);
endmodule : ztpt_top_asserts

bind ztpt_top ztpt_top_asserts #(.pwr_cyc(pwr_cyc)) ztpt_top_asserts_inst (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .ext_reset,
  .alarm_enable, .alarm_latch_clr, .main_view, .secondary_readout,
  .peak_valid
);

// >>> dv/tb.sv
// self-checking bench for the zero tare peak tracker
`timescale 1ns/1ps
module tb;
  import ztpt_pkg::*;
  localparam int k_al = 0, k_up = 1, k_sh = 2, k_mm = 3, k_ez = 4;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, key_alarm, key_up, key_shift;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic key_maxmin, ext_zero, ext_reset, out_of_range, meas_valid;
  logic alarm_latch_clr, peak_valid;
  logic signed [31:0] meas_value, display_value;
  logic [1:0] main_view;
  logic [2:0] secondary_readout;
  logic [3:0] alarm_enable;
  int fails = 0, check_count = 0;
  always #12.5 pclk = ~pclk;

  ztpt_top #(.pwr_cyc(20), .ret_cyc(30), .hold1_cyc(10), .hold2_cyc(20))
    ztpt_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .key_alarm, .key_up, .key_shift,
    .key_maxmin, .ext_zero, .ext_reset, .out_of_range, .meas_valid,
    .meas_value, .display_value, .main_view, .secondary_readout,
    .alarm_enable, .alarm_latch_clr, .peak_valid);
  ztpt_keys_model ztpt_keys_model_inst (.pclk, .key_alarm, .key_up,
    .key_shift, .key_maxmin, .ext_zero, .ext_reset, .out_of_range,
    .meas_valid, .meas_value);

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic close_out();
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, held until ready is sampled high
  task automatic xf(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for ready; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xf
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rc
  task automatic key(input int k, input int n);
    ztpt_keys_model_inst.hold(k, n);
  endtask : key
  task automatic mv(input logic signed [31:0] v);
    ztpt_keys_model_inst.meas(v);
  endtask : mv

  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc(ztpt_a_ctrl, ztpt_ctrl_rst);
    rc(ztpt_a_refv, 32'h0);
    rc(12'h030, 32'h0);
    repeat (30) @(posedge pclk);
    mv(500);
    chk(display_value, 500);
    key(k_up, 1);
    chk(display_value, 0);
    mv(700);
    chk(display_value, 200);
    key(k_up, 1);
    mv(750);
    chk(display_value, 50);
    key(k_up, 1);
    mv(760);
    chk(display_value, 10);
    key(k_up, 15);
    mv(800);
    chk(display_value, 300);
    key(k_up, 25);
    mv(800);
    chk(display_value, 800);
    wr(ztpt_a_refv, 32'h5);
    ztpt_keys_model_inst.lvl(6, 1'b1);
    key(k_up, 1);
    mv(900);
    chk(display_value, 105);
    key(k_up, 25);
    ztpt_keys_model_inst.lvl(6, 1'b0);
    wr(ztpt_a_refv, 32'h0);
    wr(ztpt_a_ctrl, 32'h1);
    key(k_up, 1);
    mv(950);
    chk(display_value, 50);
    key(k_up, 15);
    mv(950);
    chk(display_value, 950);
    wr(ztpt_a_ctrl, 32'h2);
    key(k_up, 1);
    mv(960);
    chk(display_value, 960);
    for (int i = 0; i < 2; i++) begin
      wr(ztpt_a_ctrl, {20'h0, i == 0 ? ztpt_io_6 : ztpt_io_a, 8'h02});
      mv(960);
      key(k_ez, 1);
      mv(970);
      chk(display_value, 10);
      key(k_ez, 25);
      mv(970);
      chk(display_value, 970);
    end
    wr(ztpt_a_ctrl, 32'h2);
    key(k_ez, 1);
    mv(980);
    chk(display_value, 980);
    wr(ztpt_a_ctrl, 32'h0);
    ztpt_keys_model_inst.lvl(5, 1'b1);
    key(k_up, 1);
    chk(32'(alarm_enable), 32'h0);
    chk(32'(alarm_latch_clr), 32'h1);
    ztpt_keys_model_inst.lvl(5, 1'b0);
    xf(1'b0, ztpt_a_stat, 32'h0);
    chk(32'(q[1]), 32'h0);
    chk(32'(alarm_enable), 32'hf);
    mv(1500);
    key(k_mm, 15);
    mv(2000);
    mv(1200);
    rc(ztpt_a_max, 2000);
    rc(ztpt_a_min, 1200);
    key(k_mm, 1);
    chk(32'(main_view), 32'h3);
    mv(2500);
    rc(ztpt_a_max, 2500);
    key(k_up, 1);
    xf(1'b0, ztpt_a_stat, 32'h0);
    chk(32'(q[1]), 32'h0);
    key(k_mm, 1);
    chk(32'(main_view), 32'h0);
    key(k_mm, 1);
    chk(32'(main_view), 32'h1);
    wr(ztpt_a_ctrl, 32'h8);
    key(k_mm, 1);
    chk(32'(main_view), 32'h1);
    wr(ztpt_a_ctrl, 32'h4);
    key(k_mm, 15);
    rc(ztpt_a_max, 2500);
    mv(1300);
    wr(ztpt_a_peak_clr, 32'h1);
    mv(1300);
    rc(ztpt_a_max, 1300);
    key(k_mm, 1);
    chk(32'(main_view), 32'h0);
    wr(ztpt_a_ctrl, 32'h0);
    wr(ztpt_a_sp0, 200000);
    wr(ztpt_a_sp0 + 12'h004, -30000);
    key(k_al, 1);
    chk(32'(secondary_readout), 32'h1);
    key(k_sh, 1);
    key(k_al, 1);
    chk(32'(secondary_readout), 32'h3);
    rc(ztpt_a_sp0, 100000);
    key(k_sh, 1);
    key(k_al, 1);
    rc(ztpt_a_sp0 + 12'h004, -20000);
    chk(32'(secondary_readout), 32'h2);
    key(k_al, 1);
    chk(32'(secondary_readout), 32'h6);
    key(k_al, 1);
    chk(32'(secondary_readout), 32'h0);
    key(k_al, 1);
    repeat (10) @(posedge pclk);
    chk(32'(secondary_readout), 32'h1);
    repeat (30) @(posedge pclk);
    chk(32'(secondary_readout), 32'h0);
    wr(ztpt_a_ctrl, 32'h10);
    key(k_al, 1);
    repeat (40) @(posedge pclk);
    chk(32'(secondary_readout), 32'h1);
    wr(ztpt_a_sp0 + 12'h008, ztpt_sp_off);
    repeat (2) @(posedge pclk);
    chk(32'(alarm_enable), 32'hb);
    close_out();
  end
endmodule : tb
